// [logic/frsp_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the row programmer.
// Assumes: 200 MHz mclk, APB byte addressing with one 32-bit word per register.
// Notes:   Definitions only.
`ifndef FRSP_PARAMS_SVH
`define FRSP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FRSP_ADDR_CTRL    12'h000
`define FRSP_ADDR_LOW     12'h004
`define FRSP_ADDR_UPPER   12'h008
`define FRSP_ADDR_KEY     12'h00c

// ----------------------------------------------------------------------------
// Control register fields, reset values and unlock keys
// ----------------------------------------------------------------------------
`define FRSP_BIT_START    15
`define FRSP_BIT_WRITE_ENABLE_BIT     14
`define FRSP_BIT_WERR     13
`define FRSP_BIT_DONE     12
`define FRSP_BIT_ERASE    6
`define FRSP_OP_MSB       6
`define FRSP_TYPE_MSB     3
`define FRSP_TYPE_ROW     4'h1
`define FRSP_OP_RST       7'h00
`define FRSP_ADDR_RST     16'h0000
`define FRSP_UPPER_RST    8'h00
`define FRSP_KEY_FIRST    8'h55
`define FRSP_KEY_SECOND   8'haa

// ----------------------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------------------
`define FRSP_ROW_WORDS    32
`define FRSP_ROW_BYTES    96
`define FRSP_PANEL_ROWS   128
`define FRSP_WORD_BITS    24
`define FRSP_CLK_MHZ      200
`define FRSP_OP_TIME_US   2000
`define FRSP_OP_CYCLES    (`FRSP_OP_TIME_US * `FRSP_CLK_MHZ)

`endif

// [logic/frsp_pkg.sv]
// Purpose: Types shared by the row programmer modules.
// Assumes: 24-bit program address, 32 words of 24 bits per row.
// Notes:   Numbers live in frsp_params.svh.
package frsp_pkg;

  typedef struct packed {
    logic        high;   // 1: upper byte write, 0: low word write
    logic [23:0] ea;     // effective program address
    logic [15:0] data;   // source word
  } frsp_tbl_req_t;

  typedef struct packed {
    logic        erase;  // 1: erase row, 0: program row
    logic [10:0] panel;  // panel index
    logic [6:0]  row;    // row inside the panel
  } frsp_flash_cmd_t;

  typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} frsp_key_t;
  typedef enum logic {OP_IDLE, OP_RUN} frsp_op_t;

endpackage : frsp_pkg

// [logic/frsp_latches.sv]
// Purpose: Row write latches, 32 words of 24 bits, loaded by table writes.
// Assumes: Writers index words by effective address bits 5:1.
// Notes:   Contents survive the system reset; only power-up clears them.
`timescale 1ns/1ps
`include "frsp_params.svh"
module frsp_latches
  import frsp_pkg::*;
(
  input  wire logic         mclk,      // system clock
  input  wire logic         por_rst,   // power-up reset
  input  wire logic         we_low,    // write bits 15:0 of a word
  input  wire logic         we_high,   // write bits 23:16 of a word
  input  wire logic [4:0]   idx,       // word index in the row
  input  wire logic [15:0]  wdata,     // source word
  output logic      [767:0] row_data   // all words, word 0 lowest
);

  logic [`FRSP_WORD_BITS-1:0] mem [`FRSP_ROW_WORDS];

  always_ff @(posedge mclk) begin
    if (por_rst) begin
      for (int i = 0; i < `FRSP_ROW_WORDS; i++) begin
        mem[i] <= 24'h000000;
      end
    end else begin
      if (we_low) begin
        mem[idx][15:0] <= wdata;
      end
      if (we_high) begin
        mem[idx][23:16] <= wdata[7:0];
      end
    end
  end

  for (genvar g = 0; g < `FRSP_ROW_WORDS; g++) begin : g_pack
    assign row_data[g*`FRSP_WORD_BITS +: `FRSP_WORD_BITS] = mem[g];
  end

  property p_high_byte;
    @(posedge mclk) disable iff (por_rst)
    we_high |=> mem[$past(idx)][23:16] == $past(wdata[7:0]);
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("upper byte not stored");

  property p_low_word;
    @(posedge mclk) disable iff (por_rst)
    we_low |=> mem[$past(idx)][15:0] == $past(wdata);
  endproperty
  a_low_word: assert property (p_low_word) else $error("low word not stored");

endmodule : frsp_latches

// [logic/frsp_ctrl.sv]
// Purpose: Run-time row erase/program sequencer with APB registers and write latches.
// Assumes: Table writes come from CPU logic on mclk; flash macro follows flash_go.
// Notes:   APB and table port stall while an operation runs.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "frsp_params.svh"
module frsp_ctrl
  import frsp_pkg::*;
#(
  parameter int unsigned OP_CYCLES = `FRSP_OP_CYCLES
) (
  input  wire logic            mclk,                 // 200 MHz system clock
  input  wire logic            srst,                 // clear or watchdog reset
  input  wire logic            por_rst,              // power-up reset
  input  wire logic [11:0]     paddr,                // APB address
  input  wire logic            psel,                 // APB select
  input  wire logic            penable,              // APB enable
  input  wire logic            pwrite,               // APB direction
  input  wire logic [31:0]     pwdata,               // APB write data
  output logic      [31:0]     prdata,               // APB read data
  output logic                 pready,               // APB ready
  output logic                 pslverr,              // APB error
  input  wire logic            tbl_valid,            // table write request
  input  wire frsp_tbl_req_t   tbl_req,              // table write payload
  output logic                 tbl_ready,            // table write accepted
  output logic                 tbl_done,             // table write complete
  output logic                 cpu_stall,            // processor stall
  output logic                 flash_go,             // start pulse to flash
  output frsp_flash_cmd_t      flash_cmd,            // row operation
  output logic      [767:0]    flash_row_data,       // latch contents
  output logic                 mem_op_done_irq_flag  // done flag level
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  frsp_key_t   key_state;
  frsp_op_t    op_state;
  logic        ctrl_start;
  logic        write_enable_bit;
  logic        write_error_flag;
  logic [6:0]  ctrl_op;
  logic [15:0] flash_addr_low;
  logic [7:0]  flash_addr_upper;
  logic [18:0] op_cnt;
  logic        rd_valid;
  logic        busy;
  logic        wr_en;
  logic        hit;
  logic        launch;
  logic        tbl_take;
  logic        op_end;
  logic [15:0] ctrl_rd;

  assign busy      = (op_state == OP_RUN);
  assign cpu_stall = busy;
  assign tbl_ready = !busy;
  assign tbl_take  = tbl_valid && tbl_ready;
  assign op_end    = busy && (op_cnt == 19'h00000);

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  // Ready waits one cycle after the stall ends so the read data flop is fresh.
  assign pready  = psel && rd_valid && !busy;
  assign hit     = (paddr == `FRSP_ADDR_CTRL) || (paddr == `FRSP_ADDR_LOW)
                || (paddr == `FRSP_ADDR_UPPER) || (paddr == `FRSP_ADDR_KEY);
  assign pslverr = psel && penable && pready && !hit;
  assign wr_en   = psel && penable && pready && pwrite && hit;
  assign ctrl_rd = {ctrl_start, write_enable_bit, write_error_flag,
                    mem_op_done_irq_flag, 5'h00, ctrl_op};

  always_ff @(posedge mclk) begin
    if (por_rst || srst) begin
      rd_valid <= 1'b0;
      prdata   <= 32'h00000000;
    end else begin
      rd_valid <= psel && !busy;
      unique case (paddr)
        `FRSP_ADDR_CTRL:  prdata <= {16'h0000, ctrl_rd};
        `FRSP_ADDR_LOW:   prdata <= {16'h0000, flash_addr_low};
        `FRSP_ADDR_UPPER: prdata <= {24'h000000, flash_addr_upper};
        default:          prdata <= 32'h00000000; // key reads as zero
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Unlock sequence
  // --------------------------------------------------------------------------
  assign launch = wr_en && (paddr == `FRSP_ADDR_CTRL) && (key_state == KEY_OPEN)
               && pwdata[`FRSP_BIT_START] && pwdata[`FRSP_BIT_WRITE_ENABLE_BIT]
               && (pwdata[`FRSP_TYPE_MSB:0] == `FRSP_TYPE_ROW);

  always_ff @(posedge mclk) begin
    if (por_rst || srst) begin
      key_state <= KEY_LOCKED;
    end else if (wr_en) begin
      if (paddr == `FRSP_ADDR_KEY && pwdata[7:0] == `FRSP_KEY_FIRST) begin
        key_state <= KEY_HALF;
      end else if (paddr == `FRSP_ADDR_KEY && key_state == KEY_HALF
                   && pwdata[7:0] == `FRSP_KEY_SECOND) begin
        key_state <= KEY_OPEN;
      end else begin
        // A start attempt also spends the unlock, so each launch needs a new key.
        key_state <= KEY_LOCKED;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (por_rst) begin
      write_enable_bit <= 1'b0;
      ctrl_op          <= `FRSP_OP_RST;
    end else if (srst) begin
      write_enable_bit <= 1'b0;
      ctrl_op          <= `FRSP_OP_RST;
    end else if (wr_en && paddr == `FRSP_ADDR_CTRL) begin
      write_enable_bit <= pwdata[`FRSP_BIT_WRITE_ENABLE_BIT];
      ctrl_op          <= pwdata[`FRSP_OP_MSB:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (por_rst || srst) begin
      ctrl_start <= 1'b0;
    end else if (launch) begin
      ctrl_start <= 1'b1;
    end else if (op_end) begin
      ctrl_start <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (por_rst) begin
      write_error_flag <= 1'b0;
    end else if (srst) begin
      write_error_flag <= write_error_flag || busy;
    end else if (wr_en && paddr == `FRSP_ADDR_CTRL) begin
      write_error_flag <= pwdata[`FRSP_BIT_WERR];
    end
  end

  always_ff @(posedge mclk) begin
    if (por_rst || srst) begin
      mem_op_done_irq_flag <= 1'b0;
    end else if (op_end) begin
      mem_op_done_irq_flag <= 1'b1;
    end else if (wr_en && paddr == `FRSP_ADDR_CTRL && !pwdata[`FRSP_BIT_DONE]) begin
      mem_op_done_irq_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Address registers
  // --------------------------------------------------------------------------
  // A table write in the same cycle as an APB address write wins: it is newer.
  always_ff @(posedge mclk) begin
    if (por_rst) begin
      flash_addr_low   <= `FRSP_ADDR_RST;
      flash_addr_upper <= `FRSP_UPPER_RST;
    end else if (srst) begin
      flash_addr_low   <= flash_addr_low;
      flash_addr_upper <= flash_addr_upper;
    end else if (tbl_take) begin
      flash_addr_low   <= tbl_req.ea[15:0];
      flash_addr_upper <= tbl_req.ea[23:16];
    end else if (wr_en && paddr == `FRSP_ADDR_LOW) begin
      flash_addr_low   <= pwdata[15:0];
    end else if (wr_en && paddr == `FRSP_ADDR_UPPER) begin
      flash_addr_upper <= pwdata[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Table write port and latches
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (por_rst || srst) begin
      tbl_done <= 1'b0;
    end else begin
      tbl_done <= tbl_take;
    end
  end

  frsp_latches u_latches (
    .mclk     (mclk),
    .por_rst  (por_rst),
    .we_low   (tbl_take && !tbl_req.high),
    .we_high  (tbl_take && tbl_req.high),
    .idx      (tbl_req.ea[5:1]),
    .wdata    (tbl_req.data),
    .row_data (flash_row_data)
  );

  // --------------------------------------------------------------------------
  // Operation sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (por_rst || srst) begin
      op_state <= OP_IDLE;
      op_cnt   <= 19'h00000;
      flash_go <= 1'b0;
      flash_cmd <= '0;
    end else begin
      flash_go <= launch;
      unique case (op_state)
        OP_IDLE: begin
          if (launch) begin
            op_state        <= OP_RUN;
            op_cnt          <= 19'(OP_CYCLES - 1);
            flash_cmd.erase <= pwdata[`FRSP_BIT_ERASE];
            flash_cmd.panel <= {flash_addr_upper, flash_addr_low[15:13]};
            flash_cmd.row   <= flash_addr_low[12:6];
          end
        end
        OP_RUN: begin
          if (op_cnt == 19'h00000) begin
            op_state <= OP_IDLE;
          end else begin
            op_cnt <= op_cnt - 19'h00001;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [18:0] chk_len;

  always_ff @(posedge mclk) begin
    if (por_rst || srst) begin
      chk_len <= 19'h00000;
    end else begin
      chk_len <= busy ? chk_len + 19'h00001 : 19'h00000;
    end
  end

  property p_op_len;
    @(posedge mclk) disable iff (por_rst || srst)
    $fell(busy) && !$past(srst) |-> chk_len == 19'(OP_CYCLES);
  endproperty
  a_op_len: assert property (p_op_len) else $error("operation length wrong");

  property p_key_open;
    @(posedge mclk) disable iff (por_rst || srst)
    launch |-> $past(key_state) == KEY_OPEN ##1 key_state == KEY_LOCKED && ctrl_start;
  endproperty
  a_key_open: assert property (p_key_open) else $error("start without unlock");

  property p_cancel;
    @(posedge mclk) disable iff (por_rst || srst)
    (key_state == KEY_HALF && wr_en && paddr != `FRSP_ADDR_KEY) |=> key_state == KEY_LOCKED;
  endproperty
  a_cancel: assert property (p_cancel) else $error("unlock not cancelled");

  property p_start_hold;
    @(posedge mclk) disable iff (por_rst || srst)
    $fell(ctrl_start) && !$past(srst) |-> $past(op_end);
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start cleared early");

  property p_stall;
    @(posedge mclk) disable iff (por_rst || srst)
    launch |=> busy && cpu_stall && ctrl_start && !pready && !tbl_ready;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall after launch");

  property p_tbl_done;
    @(posedge mclk) disable iff (por_rst || srst)
    1'b1 |=> tbl_done == $past(tbl_take);
  endproperty
  a_tbl_done: assert property (p_tbl_done) else $error("table write not done");

  property p_capture;
    @(posedge mclk) disable iff (por_rst || srst)
    tbl_take |=> flash_addr_low == $past(tbl_req.ea[15:0])
              && flash_addr_upper == $past(tbl_req.ea[23:16]);
  endproperty
  a_capture: assert property (p_capture) else $error("address not captured");

  property p_done_flag;
    @(posedge mclk) disable iff (por_rst || srst)
    op_end |=> mem_op_done_irq_flag && !ctrl_start && !busy;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag not set");

  property p_werr;
    @(posedge mclk) disable iff (por_rst)
    (srst && busy) |=> write_error_flag;
  endproperty
  a_werr: assert property (p_werr) else $error("reset abort not flagged");

  property p_write_enable_bit_gate;
    @(posedge mclk) disable iff (por_rst || srst)
    $rose(busy) |-> $past(pwdata[`FRSP_BIT_WRITE_ENABLE_BIT]) && $past(wr_en);
  endproperty
  a_write_enable_bit_gate: assert property (p_write_enable_bit_gate) else $error("launch without enable");

endmodule : frsp_ctrl

// [tb/frsp_cpu_model.sv]
// Purpose: CPU-side table write source that fills one row of write latches.
// Assumes: tbl_ready is sampled at the rising edge that takes the request.
// Notes:   The payload is inverted once released so stale data never looks valid.
`timescale 1ns/1ps
module frsp_cpu_model
  import frsp_pkg::*;
(
  input  wire logic     mclk,      // system clock
  input  wire logic     tbl_ready, // controller accepts
  output logic          tbl_valid, // table write request
  output frsp_tbl_req_t tbl_req    // table write payload
);
  initial begin
    tbl_valid = 1'b0;
    tbl_req   = '0;
  end

  // --------------------------------------------------------------------------
  // Table writes
  // --------------------------------------------------------------------------
  // The request holds until the edge that takes it; the next one follows at once.
  task automatic put(input logic h, input logic [23:0] ea, input logic [15:0] d);
    int n;
    tbl_valid <= 1'b1;
    tbl_req   <= '{high: h, ea: ea, data: d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (tbl_ready !== 1'b1 && n < 1000);
  endtask : put

  // The upper byte of each high source word is junk on purpose.
  task automatic load_row(input logic [23:0] base, input logic [15:0] k);
    @(posedge mclk);
    for (int i = 0; i < 32; i++) begin
      put(1'b0, base + 24'(2 * i), k + 16'(i) * 16'h0111);
      put(1'b1, base + 24'(2 * i), {8'hee, k[7:0] ^ 8'(i)});
    end
    tbl_valid <= 1'b0;
    tbl_req   <= ~tbl_req;
  endtask : load_row
endmodule : frsp_cpu_model

// [tb/tb.sv]
// Purpose: Self-checking bench for the row programmer over APB and table writes.
// Assumes: Operation length shortened to 20 cycles.
// Notes:   Expected values are built from register fields, not design outputs.
`timescale 1ns/1ps
`include "frsp_params.svh"
module tb
  import frsp_pkg::*;
;
  localparam int          OPC  = 20;
  localparam logic [23:0] BASE = 24'h012340;
  logic                   mclk, srst, por_rst, psel, penable, pwrite;
  logic            [11:0] paddr;
  logic            [31:0] pwdata, prdata, rdv;
  logic                   pready, pslverr, tbl_valid, tbl_ready, tbl_done;
  logic                   cpu_stall, flash_go, done_flag, rerr;
  frsp_tbl_req_t          tbl_req;
  frsp_flash_cmd_t        flash_cmd;
  logic           [767:0] flash_row_data;
  logic            [15:0] ctrl, last_low;
  int                     mismatches, checked, go_cnt, stall_cnt, done_cnt, bad_rdy;

  frsp_ctrl #(.OP_CYCLES(OPC)) i_dut (.mclk(mclk), .srst(srst), .por_rst(por_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tbl_valid(tbl_valid),
    .tbl_req(tbl_req), .tbl_ready(tbl_ready), .tbl_done(tbl_done),
    .cpu_stall(cpu_stall), .flash_go(flash_go), .flash_cmd(flash_cmd),
    .flash_row_data(flash_row_data), .mem_op_done_irq_flag(done_flag));
  frsp_cpu_model i_cpu (.mclk(mclk), .tbl_ready(tbl_ready), .tbl_valid(tbl_valid),
    .tbl_req(tbl_req));

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  always @(posedge mclk) begin
    if (flash_go === 1'b1) go_cnt++;
    if (cpu_stall === 1'b1) stall_cnt++;
    if (tbl_done === 1'b1) done_cnt++;
    if (cpu_stall === 1'b1 && tbl_ready !== 1'b0) bad_rdy++;
  end

  // --------------------------------------------------------------------------
  // Checks and bus tasks
  // --------------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t %s: got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // No cycle count is assumed; a wait ends on pready or after 200 cycles.
  // Called just after a rising edge; returns one edge after the access edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("Error %0t bus answer never came", $time);
      tally_and_finish();
    end
    rdv  = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp, m);
  endtask : rd

  // Keys and start go back to back with nothing in between.
  task automatic launch(input logic [15:0] c);
    wr(`FRSP_ADDR_CTRL, 32'(c));
    wr(`FRSP_ADDR_KEY, 32'h55);
    wr(`FRSP_ADDR_KEY, 32'haa);
    wr(`FRSP_ADDR_CTRL, 32'(c) | 32'h8000);
  endtask : launch

  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    $display("Error %0t run did not end", $time);
    tally_and_finish();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {srst, por_rst, psel, penable, pwrite} = 5'b11000;
    {mismatches, checked, go_cnt, stall_cnt, done_cnt, bad_rdy} = '0;
    paddr  = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge mclk);
    srst    <= 1'b0;
    por_rst <= 1'b0;
    rd(`FRSP_ADDR_CTRL, 32'h0, "control reset");
    rd(`FRSP_ADDR_LOW, 32'h0, "low address reset");
    rd(`FRSP_ADDR_UPPER, 32'h0, "upper address reset");
    wr(`FRSP_ADDR_KEY, 32'h1234);
    rd(`FRSP_ADDR_KEY, 32'h0, "key readback");
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    $display("test reset_values done");
    wr(`FRSP_ADDR_LOW, 32'hffff_a5c3);
    rd(`FRSP_ADDR_LOW, 32'h0000_a5c3, "low address write");
    wr(`FRSP_ADDR_UPPER, 32'h0000_12ab);
    rd(`FRSP_ADDR_UPPER, 32'h0000_00ab, "upper address write");
    $display("test address_regs done");
    i_cpu.load_row(BASE, 16'h3c00);
    repeat (2) @(posedge mclk);
    chk(32'(done_cnt), 32'd64, "table write completions");
    for (int i = 0; i < 32; i++)
      chk(32'(flash_row_data[24*i +: 24]), {8'h0, 8'h00 ^ 8'(i),
        16'h3c00 + 16'(i) * 16'h0111}, "latch word");
    last_low = BASE[15:0] + 16'd62;
    rd(`FRSP_ADDR_LOW, 32'(last_low), "low address capture");
    rd(`FRSP_ADDR_UPPER, 32'(BASE[23:16]), "upper address capture");
    $display("test latch_load done");
    for (int k = 0; k < 2; k++) begin
      ctrl = (k == 0) ? 16'h4041 : 16'h4001;
      go_cnt    = 0;
      stall_cnt = 0;
      launch(ctrl);
      rd(`FRSP_ADDR_CTRL, 32'(ctrl) | 32'h1000, "start cleared, done set");
      chk(32'(stall_cnt), 32'(OPC), "stall length");
      chk(32'(go_cnt), 32'd1, "one flash start");
      chk(32'(flash_cmd), 32'({k == 0, BASE[23:16], last_low[15:13], last_low[12:6]}),
        "flash command");
      chk({31'h0, done_flag}, 32'h1, "done flag set");
      wr(`FRSP_ADDR_CTRL, 32'(ctrl));
      chk({31'h0, done_flag}, 32'h0, "done flag cleared");
    end
    chk(32'(bad_rdy), 32'h0, "table port refused while busy");
    $display("test erase_program done");
    go_cnt = 0;
    wr(`FRSP_ADDR_CTRL, 32'h4001);
    wr(`FRSP_ADDR_KEY, 32'h55);
    wr(`FRSP_ADDR_LOW, 32'(last_low));
    wr(`FRSP_ADDR_KEY, 32'haa);
    wr(`FRSP_ADDR_CTRL, 32'hc001);
    wr(`FRSP_ADDR_KEY, 32'h55);
    wr(`FRSP_ADDR_KEY, 32'haa);
    wr(`FRSP_ADDR_CTRL, 32'h8001);
    wr(`FRSP_ADDR_KEY, 32'haa);
    wr(`FRSP_ADDR_KEY, 32'h55);
    wr(`FRSP_ADDR_CTRL, 32'hc001);
    rd(`FRSP_ADDR_CTRL, 32'h4001, "start refused");
    chk(32'(go_cnt), 32'h0, "no flash start");
    $display("test key_refusal done");
    launch(16'h4001);
    repeat (5) @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    rd(`FRSP_ADDR_CTRL, 32'h2000, "control after abort");
    chk(rdv & 32'ha000, 32'h2000, "error flag after abort");
    rd(`FRSP_ADDR_LOW, 32'(last_low), "address kept after abort");
    $display("test abort done");
    tally_and_finish();
  end
endmodule : tb
